// ===== rtl/sacc_defs.svh
/*
 Constants for the SAR conversion and output coding block: register map,
 field positions, reset values, result codes and timing counts.
 Assumes a 100 MHz sys_clk and a 32-bit AXI4-Lite register bus.
*/
`ifndef SACC_DEFS_SVH
`define SACC_DEFS_SVH

// -----------------------------------------------------------------------
// Register map (byte addresses)
// -----------------------------------------------------------------------
`define SACC_ADDR_W        8
`define SACC_CFG_OFFS      8'h00
`define SACC_STAT_OFFS     8'h04
`define SACC_RES_OFFS      8'h08
`define SACC_RESP_OKAY     2'h0
`define SACC_RESP_SLVERR   2'h2

// -----------------------------------------------------------------------
// Configuration fields and reset values
// -----------------------------------------------------------------------
`define SACC_CFG_POL_BIT   2
`define SACC_CFG_SPAN_BIT  1
`define SACC_CFG_CODE_BIT  0
`define SACC_CFG_RST       3'h1
`define SACC_MODE_PAR18    2'h0
`define SACC_MODE_SERIAL   2'h3

// -----------------------------------------------------------------------
// Status fields
// -----------------------------------------------------------------------
`define SACC_STAT_BUSY     0
`define SACC_STAT_TRACK    1
`define SACC_STAT_SW       2
`define SACC_STAT_CFG_LO   4
`define SACC_STAT_STATE_LO 8

// -----------------------------------------------------------------------
// Result codes
// -----------------------------------------------------------------------
`define SACC_RES_W         18
`define SACC_MSB_MASK      18'h20000
`define SACC_FS_SB         18'h3ffff
`define SACC_FS_TC         18'h1ffff
`define SACC_NFS_SB        18'h00000
`define SACC_NFS_TC        18'h20000

// -----------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------
`define SACC_CLK_MHZ       100
`define SACC_PERIOD_NS     4000
`define SACC_PERIOD_CYC    ((`SACC_PERIOD_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_ACQ_NS        1000
`define SACC_ACQ_CYC       ((`SACC_ACQ_NS * `SACC_CLK_MHZ + 999) / 1000)
`define SACC_STEP_CYC      4
`define SACC_CNT_W         16

`endif

// ===== rtl/sacc_pkg.sv
/*
 Types shared by the SAR conversion and output coding block.
 Assumes sacc_defs.svh for all numeric constants.
*/
package sacc_pkg;

   // --------------------------------------------------------------------
   // Sequencer states
   // --------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_ACQ  = 4'h1,
      ST_WAIT = 4'h2,
      ST_CONV = 4'h4,
      ST_CODE = 4'h8
   } sacc_state_type;

   // --------------------------------------------------------------------
   // Pin group and configuration word
   // --------------------------------------------------------------------
   typedef struct packed {
      logic       convert_start_n;
      logic       comparator_high;
      logic       overrange;
      logic       underrange;
      logic [1:0] interface_mode;
      logic       pin_or_register_config_select;
      logic       range_polarity_select;
      logic       range_span_select;
      logic       output_coding_select;
   } sacc_pins_type;

   typedef struct packed {
      logic range_polarity_select;
      logic range_span_select;
      logic output_coding_select;
   } sacc_cfg_type;

endpackage : sacc_pkg

// ===== rtl/sacc_sar_engine.sv
/*
 Successive approximation engine: walks an 18-bit trial code from the MSB
 down, one decision every step period.
 Assumes comparator_high is already synchronised to sys_clk.
*/
`include "sacc_defs.svh"

module sacc_sar_engine (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   rst,
   // Control
   input  wire logic                   start,
   input  wire logic                   comparator_high,
   output logic                        done,
   // Codes
   output logic [`SACC_RES_W-1:0]      trial_code,
   output logic [`SACC_RES_W-1:0]      final_code
);

   logic                        run_r;
   logic [`SACC_CNT_W-1:0]      cnt_r;
   logic [`SACC_RES_W-1:0]      mask_r;
   logic [`SACC_RES_W-1:0]      trial_r;
   logic                        decide;
   logic [`SACC_RES_W-1:0]      keep;

   assign decide     = run_r && (cnt_r == `SACC_CNT_W'(`SACC_STEP_CYC - 1));
   // Drop the trial bit when the input sits below the trial level
   assign keep       = comparator_high ? trial_r : (trial_r & ~mask_r);
   assign done       = decide && mask_r[0];
   assign final_code = keep;
   assign trial_code = trial_r;

   // --------------------------------------------------------------------
   // Binary search, MSB first
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         run_r   <= 1'b0;
         cnt_r   <= '0;
         mask_r  <= '0;
         trial_r <= '0;
      end else if (start) begin
         run_r   <= 1'b1;
         cnt_r   <= '0;
         mask_r  <= `SACC_MSB_MASK;
         trial_r <= `SACC_MSB_MASK;
      end else if (decide) begin
         cnt_r   <= '0;
         mask_r  <= mask_r >> 1;
         trial_r <= keep | (mask_r >> 1);
         if (mask_r[0]) begin
            run_r <= 1'b0;
         end
      end else if (run_r) begin
         cnt_r <= cnt_r + `SACC_CNT_W'(1);
      end
   end

endmodule : sacc_sar_engine

// ===== rtl/sacc_top.sv
/*
 Conversion sequencer, output coding and range selection for an 18-bit
 SAR converter, with an AXI4-Lite slave for configuration and status.
 Assumes all pin inputs are asynchronous to sys_clk; the analog side
 follows trial_code, track and active_cfg.
*/
`include "sacc_defs.svh"

// Operation
// - Conversion starts only after acquisition ends and convert_start_n falls.
// - Resolve 18 bits by binary search, MSB first, down to one step.
// - Form the output code, then drop busy to show the result ready.
// - Straight binary or twos complement; not selectable in 18-bit parallel.
// - With register coding, ignore output_coding_select; far side holds it.
// - Full scale or overrange gives 0x3FFFF binary or 0x1FFFF twos.
// - Negative full scale or underrange gives 0x00000 or 0x20000.
// - Parallel and serial hardware modes take range from the pins.
// - With register range, ignore range pins; far side ties them.
// - Four ranges; write-only configuration register, rewritable any time.
// - New settings apply within one acquisition, no reset needed.
// - No pipeline latency: result belongs to its own convert start.
// - At most one conversion start per 4 microseconds.
// - Register configuration when interface mode is 3 and select pin low.
module sacc_top (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      rst,
   // Device pins
   input  wire sacc_pkg::sacc_pins_type   pins,
   output logic                           busy,
   output logic [`SACC_RES_W-1:0]         result_code,
   // Analog control
   output logic                           track,
   output logic [`SACC_RES_W-1:0]         trial_code,
   output sacc_pkg::sacc_cfg_type         active_cfg,
   // AXI4-Lite write
   input  wire logic [`SACC_ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   // AXI4-Lite read
   input  wire logic [`SACC_ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);

   // --------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------
   sacc_pkg::sacc_pins_type  pins_m_r;
   sacc_pkg::sacc_pins_type  pins_s_r;
   logic                     cnv_d_r;
   logic                     cnv_fall;
   sacc_pkg::sacc_state_type state_r;
   sacc_pkg::sacc_cfg_type   cfg_reg_r;
   sacc_pkg::sacc_cfg_type   act_cfg_r;
   sacc_pkg::sacc_cfg_type   cfg_nxt;
   logic                     act_sw_r;
   logic                     sw_mode;
   logic                     par18;
   logic [`SACC_CNT_W-1:0]   acq_cnt_r;
   logic [`SACC_CNT_W-1:0]   period_cnt_r;
   logic                     period_ok;
   logic                     sar_start;
   logic                     sar_done;
   logic [`SACC_RES_W-1:0]   sar_code;
   logic [`SACC_RES_W-1:0]   raw_r;
   logic [`SACC_RES_W-1:0]   result_r;
   logic [`SACC_RES_W-1:0]   result_nxt;
   logic                     busy_r;
   logic                     track_r;
   logic                     aw_got_r;
   logic                     w_got_r;
   logic [`SACC_ADDR_W-1:0]  aw_addr_r;
   logic [31:0]              w_data_r;
   logic [3:0]               w_strb_r;
   logic                     wr_fire;
   logic                     bvalid_r;
   logic [1:0]               bresp_r;
   logic                     rvalid_r;
   logic [1:0]               rresp_r;
   logic [31:0]              rdata_r;
   logic [31:0]              status;
   logic [2:0]               wr_sel;

   // One-hot select: bit0 config, bit1 status, bit2 result
   function automatic logic [2:0] reg_sel(
      input logic [`SACC_ADDR_W-1:0] addr);
      reg_sel = {addr == `SACC_RES_OFFS, addr == `SACC_STAT_OFFS,
                 addr == `SACC_CFG_OFFS};
   endfunction : reg_sel

   // --------------------------------------------------------------------
   // Pin synchroniser
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pins_m_r <= '1;
         pins_s_r <= '1;
         cnv_d_r  <= 1'b1;
      end else begin
         pins_m_r <= pins;
         pins_s_r <= pins_m_r;
         cnv_d_r  <= pins_s_r.convert_start_n;
      end
   end

   assign cnv_fall = cnv_d_r && !pins_s_r.convert_start_n;

   // --------------------------------------------------------------------
   // Configuration source selection
   // --------------------------------------------------------------------
   assign sw_mode = (pins_s_r.interface_mode == `SACC_MODE_SERIAL) &&
                    !pins_s_r.pin_or_register_config_select;
   assign par18   = (pins_s_r.interface_mode == `SACC_MODE_PAR18);

   always_comb begin
      if (sw_mode) begin
         cfg_nxt = cfg_reg_r;
      end else begin
         cfg_nxt.range_polarity_select = pins_s_r.range_polarity_select;
         cfg_nxt.range_span_select     = pins_s_r.range_span_select;
         cfg_nxt.output_coding_select  = pins_s_r.output_coding_select;
      end
      if (par18) begin
         cfg_nxt.output_coding_select = 1'b1;
      end
   end

   // Settings are picked up at the end of every acquisition
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         act_cfg_r <= sacc_pkg::sacc_cfg_type'(`SACC_CFG_RST);
         act_sw_r  <= 1'b0;
      end else if (state_r == sacc_pkg::ST_ACQ &&
                   acq_cnt_r == `SACC_CNT_W'(`SACC_ACQ_CYC - 1)) begin
         act_cfg_r <= cfg_nxt;
         act_sw_r  <= sw_mode;
      end
   end

   // --------------------------------------------------------------------
   // Throughput limit
   // --------------------------------------------------------------------
   assign period_ok = period_cnt_r >= `SACC_CNT_W'(`SACC_PERIOD_CYC - 1);
   assign sar_start = (state_r == sacc_pkg::ST_WAIT) && cnv_fall &&
                      period_ok;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         period_cnt_r <= `SACC_CNT_W'(`SACC_PERIOD_CYC - 1);
      end else if (sar_start) begin
         period_cnt_r <= '0;
      end else if (!period_ok) begin
         period_cnt_r <= period_cnt_r + `SACC_CNT_W'(1);
      end
   end

   // --------------------------------------------------------------------
   // Conversion sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_r   <= sacc_pkg::ST_ACQ;
         acq_cnt_r <= '0;
         busy_r    <= 1'b0;
         track_r   <= 1'b1;
      end else begin
         unique case (state_r)
            sacc_pkg::ST_ACQ: begin
               if (acq_cnt_r == `SACC_CNT_W'(`SACC_ACQ_CYC - 1)) begin
                  state_r <= sacc_pkg::ST_WAIT;
               end else begin
                  acq_cnt_r <= acq_cnt_r + `SACC_CNT_W'(1);
               end
            end
            sacc_pkg::ST_WAIT: begin
               if (sar_start) begin
                  state_r <= sacc_pkg::ST_CONV;
                  busy_r  <= 1'b1;
                  track_r <= 1'b0;
               end
            end
            sacc_pkg::ST_CONV: begin
               if (sar_done) begin
                  state_r <= sacc_pkg::ST_CODE;
               end
            end
            sacc_pkg::ST_CODE: begin
               state_r   <= sacc_pkg::ST_ACQ;
               acq_cnt_r <= '0;
               busy_r    <= 1'b0;
               track_r   <= 1'b1;
            end
         endcase
      end
   end

   sacc_sar_engine u_sar (
      .sys_clk         (sys_clk),
      .rst             (rst),
      .start           (sar_start),
      .comparator_high (pins_s_r.comparator_high),
      .done            (sar_done),
      .trial_code      (trial_code),
      .final_code      (sar_code)
   );

   // --------------------------------------------------------------------
   // Output coding
   // --------------------------------------------------------------------
   always_comb begin
      if (pins_s_r.overrange) begin
         result_nxt = act_cfg_r.output_coding_select ?
                      `SACC_FS_SB : `SACC_FS_TC;
      end else if (pins_s_r.underrange) begin
         result_nxt = act_cfg_r.output_coding_select ?
                      `SACC_NFS_SB : `SACC_NFS_TC;
      end else if (act_cfg_r.output_coding_select) begin
         result_nxt = raw_r;
      end else begin
         result_nxt = raw_r ^ `SACC_MSB_MASK;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         raw_r    <= '0;
         result_r <= '0;
      end else begin
         if (state_r == sacc_pkg::ST_CONV && sar_done) begin
            raw_r <= sar_code;
         end
         if (state_r == sacc_pkg::ST_CODE) begin
            result_r <= result_nxt;
         end
      end
   end

   assign busy        = busy_r;
   assign track       = track_r;
   assign result_code = result_r;
   assign active_cfg  = act_cfg_r;

   // --------------------------------------------------------------------
   // AXI4-Lite write channel
   // --------------------------------------------------------------------
   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready  = !w_got_r && !bvalid_r;
   assign wr_fire       = aw_got_r && w_got_r && !bvalid_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         aw_got_r  <= 1'b0;
         aw_addr_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_got_r  <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_got_r  <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         w_got_r  <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_got_r  <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_got_r  <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= `SACC_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r  <= (reg_sel(aw_addr_r) == 3'h0) ?
                     `SACC_RESP_SLVERR : `SACC_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign wr_sel = reg_sel(aw_addr_r);

   // Configuration may be rewritten at any time
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg_reg_r <= sacc_pkg::sacc_cfg_type'(`SACC_CFG_RST);
      end else if (wr_fire && wr_sel[0] && w_strb_r[0]) begin
         cfg_reg_r <= sacc_pkg::sacc_cfg_type'(w_data_r[2:0]);
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // --------------------------------------------------------------------
   // AXI4-Lite read channel
   // --------------------------------------------------------------------
   always_comb begin
      status = '0;
      status[`SACC_STAT_BUSY]  = busy_r;
      status[`SACC_STAT_TRACK] = track_r;
      status[`SACC_STAT_SW]    = act_sw_r;
      status[`SACC_STAT_CFG_LO +: 3]   = act_cfg_r;
      status[`SACC_STAT_STATE_LO +: 4] = state_r;
   end

   assign s_axi_arready = !rvalid_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rvalid_r <= 1'b0;
         rresp_r  <= `SACC_RESP_OKAY;
         rdata_r  <= '0;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rresp_r  <= `SACC_RESP_OKAY;
         unique case (reg_sel(s_axi_araddr))
            3'h1:    rdata_r <= '0; // write-only configuration
            3'h2:    rdata_r <= status;
            3'h4:    rdata_r <= {14'h0, result_r};
            default: begin
               rdata_r <= '0;
               rresp_r <= `SACC_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp  = rresp_r;
   assign s_axi_rdata  = rdata_r;

   // --------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------
   property p_start_after_acq;
      @(posedge sys_clk) disable iff (rst)
      $rose(busy_r) |-> $past(state_r) == sacc_pkg::ST_WAIT &&
                        $past(cnv_fall);
   endproperty
   a_start_after_acq: assert property (p_start_after_acq)
      else $error("conversion began outside a completed acquisition");

   property p_msb_first;
      @(posedge sys_clk) disable iff (rst)
      sar_start |=> trial_code == `SACC_MSB_MASK ##72 state_r ==
                    sacc_pkg::ST_CODE;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("search did not start at MSB or took wrong length");

   property p_busy_after_code;
      @(posedge sys_clk) disable iff (rst)
      $fell(busy_r) |-> $past(state_r) == sacc_pkg::ST_CODE &&
                        result_r == $past(result_nxt);
   endproperty
   a_busy_after_code: assert property (p_busy_after_code)
      else $error("busy fell before the code was formed");

   property p_over_sat;
      @(posedge sys_clk) disable iff (rst)
      (state_r == sacc_pkg::ST_CODE && pins_s_r.overrange) |=>
         result_r == (act_cfg_r.output_coding_select ?
                      `SACC_FS_SB : `SACC_FS_TC);
   endproperty
   a_over_sat: assert property (p_over_sat)
      else $error("overrange code wrong");

   property p_under_sat;
      @(posedge sys_clk) disable iff (rst)
      (state_r == sacc_pkg::ST_CODE && !pins_s_r.overrange &&
       pins_s_r.underrange) |=>
         result_r == (act_cfg_r.output_coding_select ?
                      `SACC_NFS_SB : `SACC_NFS_TC);
   endproperty
   a_under_sat: assert property (p_under_sat)
      else $error("underrange code wrong");

   property p_twos_msb;
      @(posedge sys_clk) disable iff (rst)
      (state_r == sacc_pkg::ST_CODE && !pins_s_r.overrange &&
       !pins_s_r.underrange && !act_cfg_r.output_coding_select) |=>
         result_r == ($past(raw_r) ^ `SACC_MSB_MASK);
   endproperty
   a_twos_msb: assert property (p_twos_msb)
      else $error("twos complement is not MSB-inverted binary");

   property p_rate_limit;
      @(posedge sys_clk) disable iff (rst)
      sar_start |=> !sar_start [*8] ##1 period_cnt_r == 16'h0008;
   endproperty
   a_rate_limit: assert property (p_rate_limit)
      else $error("conversion start spacing not tracked");

   property p_cfg_stable;
      @(posedge sys_clk) disable iff (rst)
      (state_r != sacc_pkg::ST_ACQ) |=> $stable(act_cfg_r);
   endproperty
   a_cfg_stable: assert property (p_cfg_stable)
      else $error("settings changed outside acquisition");

   property p_sw_source;
      @(posedge sys_clk) disable iff (rst)
      (state_r == sacc_pkg::ST_ACQ ##1 state_r == sacc_pkg::ST_WAIT) |->
         !$past(sw_mode) || $past(par18) ||
         act_cfg_r == $past(cfg_reg_r);
   endproperty
   a_sw_source: assert property (p_sw_source)
      else $error("register settings not used in software mode");

   property p_par18_binary;
      @(posedge sys_clk) disable iff (rst)
      (state_r == sacc_pkg::ST_ACQ ##1 state_r == sacc_pkg::ST_WAIT) |->
         !$past(par18) || act_cfg_r.output_coding_select;
   endproperty
   a_par18_binary: assert property (p_par18_binary)
      else $error("coding not straight binary in 18-bit parallel");

endmodule : sacc_top

// ===== test/sacc_host_model.sv
/*
 Far-side model: analog comparator that holds one sampled level.
 Assumes the level is steady for the whole conversion.
*/
module sacc_host_model (
   // Analog side
   input  wire logic [17:0] trial_code,
   input  wire logic [17:0] level,
   // Comparator
   output logic             comparator_high
);
   timeunit 1ns;
   timeprecision 1ps;
   assign comparator_high = (level >= trial_code);
endmodule : sacc_host_model

// ===== test/tb.sv
/*
 Bench for sacc_top: AXI4-Lite tasks and conversion sequences.
 Assumes sacc_defs.svh and the comparator model.
*/
`include "sacc_defs.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst = 1, cs_n = 1, ov = 0, un = 0, sel = 1;
   logic pol = 0, spn = 0, cod = 0, cmp, busy, track;
   logic [1:0] md = 0;
   logic [17:0] lv = 0, res, trial;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rdt, d;
   logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic awr, wr_, bv, arr, rv;
   logic [1:0] bresp, rresp, r;
   sacc_pkg::sacc_cfg_type acfg;
   wire sacc_pkg::sacc_pins_type pins =
      {cs_n, cmp, ov, un, md, sel, pol, spn, cod};
   int err_total = 0, tests_run = 0;
   always #5 sys_clk = ~sys_clk;
   sacc_host_model HM (.trial_code(trial), .level(lv),
      .comparator_high(cmp));
   sacc_top DUT (.sys_clk(sys_clk), .rst(rst), .pins(pins), .busy(busy),
      .result_code(res), .track(track), .trial_code(trial),
      .active_cfg(acfg), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdt),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr));
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task automatic chk(input logic [31:0] a, input logic [31:0] e);
      tests_run++;
      if (a !== e) begin
         err_total++;
         $display("CHECK FAILED %0t got %h exp %h", $time, a, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic pa, pw, pb;
      @(posedge sys_clk);
      {awa, wd, awv, wv, br} <= {a, v, 3'h7};
      {pa, pw, pb} = 3'h7;
      while (pa || pw || pb) begin
         @(negedge sys_clk);
         if (bv) r = bresp;
         pb = pb && !(bv && !pa && !pw);
         pa = pa && !awr;
         pw = pw && !wr_;
         @(posedge sys_clk);
         {awv, wv, br} <= {pa, pw, pb};
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v,
                     output logic [1:0] s);
      logic pa, pd;
      @(posedge sys_clk);
      {ara, arv, rr} <= {a, 2'h3};
      {pa, pd} = 2'h3;
      while (pd) begin
         @(negedge sys_clk);
         pd = !(rv && !pa);
         pa = pa && !arr;
         {v, s} = {rdt, rresp};
         @(posedge sys_clk);
         {arv, rr} <= {pa, pd};
      end
   endtask : rd
   task automatic conv(input logic [17:0] l, input logic o, input logic u,
                       input logic [17:0] e);
      lv <= l;
      {ov, un} <= {o, u};
      repeat (450) @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (10) @(negedge sys_clk);
      chk(busy, 1);
      repeat (80) @(negedge sys_clk);
      chk({busy, track, res}, {2'h1, e});
      @(posedge sys_clk);
      cs_n <= 1'b1;
   endtask : conv
   task conclude;
      if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : conclude
   // ------------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      conv(18'h2a5c3, 0, 0, 18'h2a5c3);
      @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (30) @(negedge sys_clk);
      chk(busy, 0);
      @(posedge sys_clk);
      {cs_n, md, sel, cod} <= 5'h1d;
      wr(`SACC_CFG_OFFS, 32'h6);
      chk(r, `SACC_RESP_OKAY);
      conv(18'h12345, 0, 0, 18'h32345);
      chk(acfg, 3'h6);
      conv(18'h0, 1, 0, `SACC_FS_TC);
      conv(18'h3ffff, 0, 1, `SACC_NFS_TC);
      wr(`SACC_CFG_OFFS, 32'h1);
      chk(r, `SACC_RESP_OKAY);
      conv(18'h3ffff, 0, 0, `SACC_FS_SB);
      conv(18'h1, 0, 1, `SACC_NFS_SB);
      {md, sel, pol, spn, cod} <= 6'h1a;
      conv(18'h20000, 0, 0, 18'h0);
      chk(acfg, 3'h2);
      rd(`SACC_STAT_OFFS, d, r);
      chk(d, 32'h122);
      rd(`SACC_RES_OFFS, d, r);
      chk(d, 0);
      rd(8'h40, d, r);
      chk(r, `SACC_RESP_SLVERR);
      rd(`SACC_CFG_OFFS, d, r);
      chk(d, 0);
      wr(8'h40, 32'h0);
      chk(r, `SACC_RESP_SLVERR);
      repeat (80) @(posedge sys_clk);
      cs_n <= 1'b0;
      repeat (30) @(negedge sys_clk);
      chk(busy, 0);
      conclude();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      conclude();
   end
endmodule : tb
